/* File: src/icc_pkg.sv */
// Package of constants and types for the incremental counter core
package icc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ICC_CTRL_BASE = 8'h00;
   localparam logic [7:0] ICC_COUNT_BASE = 8'h10;
   localparam logic [7:0] ICC_STAT1_BASE = 8'h20;
   localparam logic [7:0] ICC_STAT2_BASE = 8'h30;
   localparam logic [7:0] ICC_KEY_ADDR = 8'h40;
   localparam logic [7:0] ICC_SUPPLY1_ADDR = 8'h44;
   localparam logic [7:0] ICC_SUPPLY2_ADDR = 8'h48;
   localparam logic [7:0] ICC_CHAN_STRIDE = 8'h04;
   localparam int ICC_ADDR_W = 8;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int ICC_CTRL_TYPE_LSB = 0;
   localparam int ICC_CTRL_EVAL_LSB = 4;
   localparam int ICC_CTRL_COMPACT_BIT = 8;
   localparam int ICC_CTRL_COMPAT_BIT = 9;
   localparam logic [2:0] ICC_TYPE_RESET = 3'h0;
   localparam logic [2:0] ICC_TYPE_LAST = 3'h5;

   // ----------------------------------------------------------------
   // Status word bit positions (subindex minus one)
   // ----------------------------------------------------------------
   localparam int ICC_ST1_UNDERFLOW = 3;
   localparam int ICC_ST1_OVERFLOW = 4;
   localparam int ICC_ST1_INPUT_A = 8;
   localparam int ICC_ST1_INPUT_B = 9;
   localparam int ICC_ST1_LATCH = 12;
   localparam int ICC_ST1_SYNC_ERR = 13;
   localparam int ICC_ST1_TX_STATE = 14;
   localparam int ICC_ST1_TX_TOGGLE = 15;
   localparam int ICC_ST2_DIRECTION = 0;
   localparam int ICC_ST2_DIAG = 12;
   localparam int ICC_ST2_TX_STATE = 13;
   localparam int ICC_ST2_CYCLE = 14;
   localparam int ICC_ST2_LATCH = 19;

   // ----------------------------------------------------------------
   // Key and counter ranges
   // ----------------------------------------------------------------
   localparam logic [31:0] ICC_UNLOCK_KEY = 32'h7265_7375;
   localparam logic [31:0] ICC_MAX_FULL = 32'hFFFF_FFFF;
   localparam logic [31:0] ICC_MAX_COMPACT = 32'h0000_FFFF;
   localparam logic [31:0] ICC_THIRD_FULL = 32'h5555_5555;
   localparam logic [31:0] ICC_THIRD_COMPACT = 32'h0000_5555;
   localparam logic [31:0] ICC_TWO_THIRD_FULL = 32'hAAAA_AAAA;
   localparam logic [31:0] ICC_TWO_THIRD_COMPACT = 32'h0000_AAAA;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ICC_EVAL_SINGLE = 2'h0,
      ICC_EVAL_DOUBLE = 2'h1,
      ICC_EVAL_QUAD = 2'h2
   } icc_eval_type;

   typedef enum logic [1:0] {
      ICC_SUPPLY_5V = 2'h0,
      ICC_SUPPLY_12V = 2'h1,
      ICC_SUPPLY_24V = 2'h2
   } icc_supply_type;

endpackage

/* File: src/icc_chan_if.sv */
// Interface between the register block and one channel counter
`timescale 1ns/1ps
interface icc_chan_if;
   logic [2:0] counter_mode;
   icc_pkg::icc_eval_type eval_mode;
   logic compact;
   logic set_stb;
   logic [31:0] set_value;
   logic [31:0] count;
   logic overflow;
   logic underflow;
   logic direction;

   modport regs (
      output counter_mode, eval_mode, compact, set_stb, set_value,
      input count, overflow, underflow, direction
   );
   modport core (
      input counter_mode, eval_mode, compact, set_stb, set_value,
      output count, overflow, underflow, direction
   );
endinterface

/* File: src/icc_track_sync.sv */
// Two-stage synchronizer with edge detection for encoder inputs
`timescale 1ns/1ps
module icc_track_sync #(
   parameter int WIDTH = 3
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;
   logic [2:0] fill;

   initial begin
      if (WIDTH < 1) begin
         $error("icc_track_sync: WIDTH must be at least 1");
      end
   end

   // ----------------------------------------------------------------
   // Synchronizer and edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= '0;
         stable <= '0;
         level <= '0;
         fill <= '0;
      end else begin
         fill <= {fill[1:0], 1'b1};
         meta <= raw;
         stable <= meta;
         level <= stable;
      end
   end

   assign rise = stable & ~level & {WIDTH{fill[2]}};
   assign fall = ~stable & level & {WIDTH{fill[2]}};
endmodule

/* File: src/icc_counter.sv */
// Per-channel incremental counter with wrap and wrap flags
`timescale 1ns/1ps
module icc_counter (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic a_rise,
   input wire logic a_fall,
   input wire logic b_rise,
   input wire logic b_fall,
   input wire logic a_level,
   input wire logic b_level,
   icc_chan_if.core chan
);
   logic pulse_type;
   logic a_step;
   logic b_step;
   logic a_fwd;
   logic b_fwd;
   logic step;
   logic fwd;
   logic [31:0] max_count;
   logic [31:0] third;
   logic [31:0] two_third;
   logic [31:0] cur;
   logic wrap_up;
   logic wrap_down;

   // Odd types are pulse generators
   assign pulse_type = chan.counter_mode[0];
   assign max_count = chan.compact ? icc_pkg::ICC_MAX_COMPACT : icc_pkg::ICC_MAX_FULL;
   assign third = chan.compact ? icc_pkg::ICC_THIRD_COMPACT : icc_pkg::ICC_THIRD_FULL;
   assign two_third = chan.compact ? icc_pkg::ICC_TWO_THIRD_COMPACT : icc_pkg::ICC_TWO_THIRD_FULL;
   assign cur = chan.count & max_count;

   // ----------------------------------------------------------------
   // Edge qualification and direction
   // ----------------------------------------------------------------
   always_comb begin
      a_step = 1'b0;
      b_step = 1'b0;
      unique case (chan.eval_mode)
         icc_pkg::ICC_EVAL_SINGLE: a_step = a_rise;
         icc_pkg::ICC_EVAL_DOUBLE: a_step = a_rise | a_fall;
         icc_pkg::ICC_EVAL_QUAD: begin
            a_step = a_rise | a_fall;
            b_step = (b_rise | b_fall) & ~pulse_type;
         end
         default: a_step = 1'b0;
      endcase
   end

   // A leads B: A rises while B low, B rises while A high
   assign a_fwd = pulse_type ? ~b_level : (a_rise ? ~b_level : b_level);
   assign b_fwd = b_rise ? a_level : ~a_level;
   // Coincident edges on both tracks are an invalid transition
   assign step = a_step ^ b_step;
   assign fwd = a_step ? a_fwd : b_fwd;
   assign wrap_up = step & fwd & (cur == max_count);
   assign wrap_down = step & ~fwd & (cur == '0);

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan.count <= '0;
      end else if (chan.set_stb) begin
         chan.count <= chan.set_value & max_count;
      end else if (wrap_up) begin
         chan.count <= '0;
      end else if (wrap_down) begin
         chan.count <= max_count;
      end else if (step) begin
         chan.count <= fwd ? cur + 32'h0000_0001 : cur - 32'h0000_0001;
      end else begin
         chan.count <= cur;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan.direction <= 1'b0;
      end else if (step) begin
         chan.direction <= fwd;
      end
   end

   // ----------------------------------------------------------------
   // Wrap flags: set wins, cleared once a third of the range is crossed
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan.overflow <= 1'b0;
      end else if (wrap_up) begin
         chan.overflow <= 1'b1;
      end else if (cur > third) begin
         chan.overflow <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chan.underflow <= 1'b0;
      end else if (wrap_down) begin
         chan.underflow <= 1'b1;
      end else if (cur < two_third) begin
         chan.underflow <= 1'b0;
      end
   end
endmodule

/* File: src/icc_core.sv */
// Two-channel incremental counter core with AHB-Lite register slave
//
// Contract
// - Types 0, 2, 4 select encoder input without zero pulse.
// - Types 1, 3, 5 count pulses on A, direction from B level.
// - Single evaluation counts only rising edges of track A.
// - Double evaluation counts both edges of A, never B.
// - Quadruple evaluation counts every edge of both A and B; in pulse types 1, 3, 5 the code counts only the A edges.
// - Evaluation defaults to quadruple after reset.
// - Counting up past maximum wraps to zero and keeps counting.
// - Full layout spans 0 to 2^32-1.
// - Compact layout spans 0 to 2^16-1.
// - Counting below zero continues at maximum, even with external reset.
// - Downward wrap sets the channel underflow flag.
// - Upward wrap sets the channel overflow flag.
// - Supply writes accepted only while key holds 0x72657375.
// - Supply taken from channel one object, applied to both channels.
// - Channel two supply object is ignored.
// - Supply offers 5, 12, 24 volts, defaulting to 5 volts.
// - Normal mode: diag, transmit state, cycle, latch in second status.
// - Compat mode: latch, sync error, transmit state, toggle in first status.
// - Compat mode disables direction detection; keeps host counter set. The code still counts both ways, only hiding the direction bit.
// - Encoder counts forward when A leads B, backward when lagging.
// - Pulse generator counts forward while B low, backward while high.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module icc_core #(
   parameter int CHANNELS = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [CHANNELS-1:0] enc_a,
   input wire logic [CHANNELS-1:0] enc_b,
   input wire logic [CHANNELS-1:0] ext_latch,
   output icc_pkg::icc_supply_type supply_sel
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   initial begin
      if (CHANNELS != 2) begin
         $error("icc_core: CHANNELS must be 2, register map holds two channels");
      end
   end

   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic take;
   logic dp_write;
   logic [icc_pkg::ICC_ADDR_W-1:0] dp_addr;
   logic [icc_pkg::ICC_ADDR_W-1:0] ap_addr;
   logic ap_in_map;

   assign take = hsel & htrans[1] & hready;
   assign ap_addr = haddr[icc_pkg::ICC_ADDR_W-1:0];
   assign ap_in_map = (haddr[31:icc_pkg::ICC_ADDR_W] == '0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else begin
         dp_write <= take & hwrite & ap_in_map;
         dp_addr <= ap_addr;
      end
   end

   // Zero wait state, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Shared registers: unlock key and encoder supply
   // ----------------------------------------------------------------
   logic [31:0] unlock_key;
   logic key_open;

   assign key_open = (unlock_key == icc_pkg::ICC_UNLOCK_KEY);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unlock_key <= '0;
      end else if (dp_write && dp_addr == icc_pkg::ICC_KEY_ADDR) begin
         unlock_key <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_sel <= icc_pkg::ICC_SUPPLY_5V;
      end else if (dp_write && dp_addr == icc_pkg::ICC_SUPPLY1_ADDR && key_open) begin
         unique case (hwdata[1:0])
            icc_pkg::ICC_SUPPLY_5V: supply_sel <= icc_pkg::ICC_SUPPLY_5V;
            icc_pkg::ICC_SUPPLY_12V: supply_sel <= icc_pkg::ICC_SUPPLY_12V;
            icc_pkg::ICC_SUPPLY_24V: supply_sel <= icc_pkg::ICC_SUPPLY_24V;
            default: supply_sel <= supply_sel;
         endcase
      end
   end
   // Writes to the channel two supply address fall through: no register

   // ----------------------------------------------------------------
   // Per-channel logic
   // ----------------------------------------------------------------
   logic [31:0] ctrl_rd [CHANNELS];
   logic [31:0] count_rd [CHANNELS];
   logic [31:0] stat1_rd [CHANNELS];
   logic [31:0] stat2_rd [CHANNELS];
   logic [CHANNELS-1:0] count_read;

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         localparam logic [7:0] CTRL_ADDR = 8'(icc_pkg::ICC_CTRL_BASE + ch * icc_pkg::ICC_CHAN_STRIDE);
         localparam logic [7:0] COUNT_ADDR = 8'(icc_pkg::ICC_COUNT_BASE + ch * icc_pkg::ICC_CHAN_STRIDE);
         localparam logic [7:0] STAT1_ADDR = 8'(icc_pkg::ICC_STAT1_BASE + ch * icc_pkg::ICC_CHAN_STRIDE);
         localparam logic [7:0] STAT2_ADDR = 8'(icc_pkg::ICC_STAT2_BASE + ch * icc_pkg::ICC_CHAN_STRIDE);

         icc_chan_if chan ();

         logic [2:0] lvl;
         logic [2:0] rise;
         logic [2:0] fall;
         logic [2:0] counter_mode;
         icc_pkg::icc_eval_type eval_mode;
         logic compact;
         logic compat;
         logic tx_toggle;
         logic cycle_bit;
         logic diag;
         logic ctrl_wr;
         logic set_stb;
         logic [31:0] set_value;

         icc_track_sync #(
            .WIDTH(3)
         ) u_sync (
            .hclk(hclk),
            .hresetn(hresetn),
            .raw({ext_latch[ch], enc_b[ch], enc_a[ch]}),
            .level(lvl),
            .rise(rise),
            .fall(fall)
         );

         icc_counter u_counter (
            .hclk(hclk),
            .hresetn(hresetn),
            .a_rise(rise[0]),
            .a_fall(fall[0]),
            .b_rise(rise[1]),
            .b_fall(fall[1]),
            .a_level(lvl[0]),
            .b_level(lvl[1]),
            .chan(chan.core)
         );

         assign ctrl_wr = dp_write && dp_addr == CTRL_ADDR;

         // Control register
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               counter_mode <= icc_pkg::ICC_TYPE_RESET;
               eval_mode <= icc_pkg::ICC_EVAL_QUAD;
               compact <= 1'b0;
               compat <= 1'b0;
            end else if (ctrl_wr) begin
               if (hwdata[icc_pkg::ICC_CTRL_TYPE_LSB +: 3] <= icc_pkg::ICC_TYPE_LAST) begin
                  counter_mode <= hwdata[icc_pkg::ICC_CTRL_TYPE_LSB +: 3];
               end
               unique case (hwdata[icc_pkg::ICC_CTRL_EVAL_LSB +: 2])
                  icc_pkg::ICC_EVAL_SINGLE: eval_mode <= icc_pkg::ICC_EVAL_SINGLE;
                  icc_pkg::ICC_EVAL_DOUBLE: eval_mode <= icc_pkg::ICC_EVAL_DOUBLE;
                  icc_pkg::ICC_EVAL_QUAD: eval_mode <= icc_pkg::ICC_EVAL_QUAD;
                  default: eval_mode <= eval_mode;
               endcase
               compact <= hwdata[icc_pkg::ICC_CTRL_COMPACT_BIT];
               compat <= hwdata[icc_pkg::ICC_CTRL_COMPAT_BIT];
            end
         end

         // Host write to the count register presets the counter
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               set_stb <= 1'b0;
               set_value <= '0;
            end else begin
               set_stb <= dp_write && dp_addr == COUNT_ADDR;
               set_value <= hwdata;
            end
         end

         // Transmit toggle and cycle bit advance on each count read
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               tx_toggle <= 1'b0;
               cycle_bit <= 1'b0;
            end else if (count_read[ch]) begin
               tx_toggle <= ~tx_toggle;
               cycle_bit <= ~cycle_bit;
            end
         end

         // Diagnostic: broken track B in differential pulse mode
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               diag <= 1'b0;
            end else begin
               diag <= (counter_mode == 3'h1) & ~lvl[1] & ~lvl[0];
            end
         end

         assign chan.counter_mode = counter_mode;
         assign chan.eval_mode = eval_mode;
         assign chan.compact = compact;
         assign chan.set_stb = set_stb;
         assign chan.set_value = set_value;

         assign count_read[ch] = take & ~hwrite & (ap_addr == COUNT_ADDR) & ap_in_map;

         assign ctrl_rd[ch] = {22'h00_0000, compat, compact, 2'h0,
                               eval_mode, 1'b0, counter_mode};
         assign count_rd[ch] = chan.count;

         always_comb begin
            stat1_rd[ch] = '0;
            stat1_rd[ch][icc_pkg::ICC_ST1_UNDERFLOW] = chan.underflow;
            stat1_rd[ch][icc_pkg::ICC_ST1_OVERFLOW] = chan.overflow;
            stat1_rd[ch][icc_pkg::ICC_ST1_INPUT_A] = lvl[0];
            stat1_rd[ch][icc_pkg::ICC_ST1_INPUT_B] = lvl[1];
            if (compat) begin
               stat1_rd[ch][icc_pkg::ICC_ST1_LATCH] = lvl[2];
               stat1_rd[ch][icc_pkg::ICC_ST1_SYNC_ERR] = 1'b0;
               stat1_rd[ch][icc_pkg::ICC_ST1_TX_STATE] = 1'b0;
               stat1_rd[ch][icc_pkg::ICC_ST1_TX_TOGGLE] = tx_toggle;
            end
         end

         always_comb begin
            stat2_rd[ch] = '0;
            if (!compat) begin
               stat2_rd[ch][icc_pkg::ICC_ST2_DIRECTION] = chan.direction;
               stat2_rd[ch][icc_pkg::ICC_ST2_DIAG] = diag;
               stat2_rd[ch][icc_pkg::ICC_ST2_TX_STATE] = 1'b0;
               stat2_rd[ch][icc_pkg::ICC_ST2_CYCLE] = cycle_bit;
               stat2_rd[ch][icc_pkg::ICC_ST2_LATCH] = lvl[2];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data mux, registered at the address phase
   // ----------------------------------------------------------------
   logic [31:0] next_hrdata;

   always_comb begin
      next_hrdata = '0;
      if (ap_addr == icc_pkg::ICC_KEY_ADDR) begin
         next_hrdata = unlock_key;
      end else if (ap_addr == icc_pkg::ICC_SUPPLY1_ADDR) begin
         next_hrdata = {30'h0000_0000, supply_sel};
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (ap_addr == 8'(icc_pkg::ICC_CTRL_BASE + i * icc_pkg::ICC_CHAN_STRIDE)) begin
            next_hrdata = ctrl_rd[i];
         end
         if (ap_addr == 8'(icc_pkg::ICC_COUNT_BASE + i * icc_pkg::ICC_CHAN_STRIDE)) begin
            next_hrdata = count_rd[i];
         end
         if (ap_addr == 8'(icc_pkg::ICC_STAT1_BASE + i * icc_pkg::ICC_CHAN_STRIDE)) begin
            next_hrdata = stat1_rd[i];
         end
         if (ap_addr == 8'(icc_pkg::ICC_STAT2_BASE + i * icc_pkg::ICC_CHAN_STRIDE)) begin
            next_hrdata = stat2_rd[i];
         end
      end
      if (!ap_in_map) begin
         next_hrdata = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (take && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

endmodule

/* File: test/icc_enc_model.sv */
// Behavioural encoder and pulse generator driving tracks A and B
`timescale 1ns/1ps
module icc_enc_model (
   input wire logic hclk,
   input wire logic step,
   input wire logic fwd,
   input wire logic pulse,
   output logic a,
   output logic b
);
   logic [1:0] ph = 2'h0;
   always @(posedge hclk) begin
      if (step) begin
         ph <= fwd ? ph + 2'h1 : ph - 2'h1;
      end
   end
   // Pulse mode toggles A per step and holds B low for forward
   assign a = pulse ? ph[0] : ph[1] ^ ph[0];
   assign b = pulse ? !fwd : ph[1];
endmodule

/* File: test/icc_core_chk.sv */
// Checker of bus answers and supply selection of the counter core
`timescale 1ns/1ps
module icc_core_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire icc_pkg::icc_supply_type supply_sel
);
   logic dp_v, dp_w, key_ok;
   logic [31:0] dp_a;
   wire wsup = dp_v && dp_w && dp_a == 32'h0000_0044;
   wire w2 = dp_v && dp_a == 32'h0000_0048;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_v <= 1'b0;
      end else if (hready) begin
         dp_v <= hsel && htrans[1];
         dp_w <= hwrite;
         dp_a <= haddr;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_ok <= 1'b0;
      end else if (dp_v && dp_w && dp_a == 32'h0000_0040) begin
         key_ok <= hwdata == icc_pkg::ICC_UNLOCK_KEY;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_bus_ready_okay: assert property (hreadyout && !hresp) else $error("bus answer wrong");
   a_supply_locked: assert property (supply_sel != $past(supply_sel) |-> $past(wsup && key_ok))
      else $error("supply changed while locked");
   a_supply_taken: assert property (wsup && key_ok && hwdata[1:0] != 2'h3
      |=> supply_sel == $past(hwdata[1:0])) else $error("supply not taken");
   a_ch2_ignored: assert property (w2 && dp_w |=> $stable(supply_sel))
      else $error("second supply object acted");
   a_ch2_reads_zero: assert property (w2 && !dp_w |-> hrdata == 32'h0000_0000)
      else $error("second supply object read nonzero");
   a_supply_reset: assert property ($rose(hresetn) |-> supply_sel == 2'h0)
      else $error("supply not 5 V after reset");
   a_supply_legal: assert property (supply_sel != 2'h3) else $error("supply code 3");
   a_unmapped_zero: assert property (dp_v && !dp_w && dp_a[31:8] != 24'h00_0000
      |-> hrdata == 32'h0000_0000) else $error("unmapped read nonzero");
   c_supply_write: cover property (wsup && key_ok);
   c_ch2_access: cover property (w2);
   c_unmapped: cover property (dp_v && dp_a[31:8] != 24'h00_0000);
endmodule
bind icc_core icc_core_chk chk (.*);

/* File: test/tb_top.sv */
// Self-checking bench for the incremental counter core
`timescale 1ns/1ps
module tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, step = 1'b0, fwd = 1'b0;
   logic pls = 1'b0, up, oa, ob, ovf, unf, hreadyout, hresp, ma, mb;
   logic [1:0] htrans = 2'h0, lat = 2'h0, ev;
   logic [2:0] ty;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, exp_c, msk;
   logic [31:0] seed = 32'h0000_fbb1;
   logic [7:0] sa [8] = '{8'h44, 8'h40, 8'h44, 8'h48, 8'h44, 8'h44, 8'h40, 8'h44};
   logic [1:0] sd [8] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h3, 2'h1, 2'h0, 2'h0};
   logic [1:0] se [8] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
   int err_total = 0, samples_checked = 0, d;
   icc_pkg::icc_supply_type supply_sel;
   icc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .enc_a({mb, ma}), .enc_b({ma, mb}),
      .ext_latch(lat), .supply_sel(supply_sel));
   icc_enc_model enc (.hclk(hclk), .step(step), .fwd(fwd), .pulse(pls), .a(ma), .b(mb));
   always #12.5 hclk = ~hclk;
   // ----------------------------------------------------------------
   // Bus, compare and expectation helpers
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected count step of one track change
   function automatic int dlt(logic p, logic [1:0] e, logic a0, logic b0, logic a1, logic b1,
      logic f);
      if ((a1 != a0 && (e != 2'h0 || a1)) || (e == 2'h2 && !p && b1 != b0)) begin
         return f ? 1 : -1;
      end
      return 0;
   endfunction
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0020, rd);
      bus(1'b0, 32'h0000_0100, 32'h0000_0000);
      chk("unmapped read", 32'h0000_0000, rd);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 32'(sa[i]), sd[i] == 2'h1 && sa[i] == 8'h40 ? 32'h7265_7375 : 32'(sd[i]));
         @(posedge hclk);
         chk("supply", 32'(se[i]), 32'(supply_sel));
      end
      bus(1'b0, 32'h0000_0048, 32'h0000_0000);
      chk("second supply read", 32'h0000_0000, rd);
      for (int t = 0; t < 6; t++) begin
         ty = t[2:0];
         ev = 2'(t % 3);
         up = t[0];
         pls <= ty[0];
         msk = t[2] ? icc_pkg::ICC_MAX_COMPACT : icc_pkg::ICC_MAX_FULL;
         bus(1'b1, 32'h0000_0000, 32'(t[2]) << 8 | 32'(ev) << 4 | 32'(ty));
         exp_c = up ? msk : 32'h0000_0000;
         bus(1'b1, 32'h0000_0010, exp_c);
         ovf = 1'b0;
         unf = 1'b0;
         for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            fwd <= k < 12 ? up : seed[0];
            lat <= seed[2:1];
            repeat (3) @(posedge hclk);
            oa = ma;
            ob = mb;
            step <= 1'b1;
            @(posedge hclk);
            step <= 1'b0;
            @(posedge hclk);
            d = dlt(pls, ev, oa, ob, ma, mb, fwd);
            if (d > 0 && exp_c == msk) ovf = 1'b1;
            if (d < 0 && exp_c == 32'h0000_0000) unf = 1'b1;
            exp_c = (exp_c + d) & msk;
            if (exp_c > msk / 3 && !(d > 0 && exp_c == 32'h0000_0000)) ovf = 1'b0;
            if (exp_c < msk / 3 * 2 && !(d < 0 && exp_c == msk)) unf = 1'b0;
            repeat (seed[4:3]) @(posedge hclk);
         end
         repeat (6) @(posedge hclk);
         bus(1'b0, 32'h0000_0010, 32'h0000_0000);
         chk("count", exp_c, rd);
         bus(1'b0, 32'h0000_0020, 32'h0000_0000);
         chk("wrap flag", {31'h0, up ? ovf : unf}, {31'h0, rd[up ? 4 : 3]});
         $display("test %0d done", t);
      end
      bus(1'b0, 32'h0000_0030, 32'h0000_0000);
      chk("second status", {24'h0, lat[0], 7'h0}, {24'h0, rd[19:12]});
      bus(1'b1, 32'h0000_0000, 32'h0000_0237);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      chk("ctrl refused", 32'h0000_0225, rd);
      bus(1'b0, 32'h0000_0030, 32'h0000_0000);
      chk("second status in compat", 32'h0000_0000, rd);
      bus(1'b0, 32'h0000_0020, 32'h0000_0000);
      chk("compat sync and tx state", {31'h0, lat[0]}, {29'h0, rd[14:12]});
      final_report();
   end
   initial begin
      repeat (30000) @(posedge hclk);
      err_total++;
      final_report();
   end
endmodule
